// ===== core/scs_clock_select.sv
/*
 * scs_clock_select: system clock source selection and generation.
 * picks wakeup clock, direct external clock, prescaled oscillator or a
 * digital pll model, and presents the result as a level plus a tick.
 * assumes all source clocks are slower than clk_i / 2 and asynchronous
 * to it; each is brought in through two flip-flops.
 */
`timescale 1ns/1ns

module scs_clock_select
#(
   parameter int K1_W = 10,                         // prescaler divider width
   parameter int P_W  = 4,                          // pll input divider width
   parameter int N_W  = 8,                          // pll multiplier width
   parameter int K2_W = 7                           // pll output divider width
)
(
   // clock and reset
   input  wire logic        clk_i,
   input  wire logic        rst_i,
   // wishbone slave
   input  wire logic        wb_cyc_i,
   input  wire logic        wb_stb_i,
   input  wire logic        wb_we_i,
   input  wire logic [3:0]  wb_adr_i,
   input  wire logic [3:0]  wb_sel_i,
   input  wire logic [31:0] wb_dat_i,
   output logic      [31:0] wb_dat_o,
   output logic             wb_ack_o,
   // clock source pins, asynchronous
   input  wire logic        ext_clock_pin_i,
   input  wire logic        crystal_input_pin_i,
   input  wire logic        int_clock_i,
   input  wire logic        wakeup_clock_i,
   // generated system clock and analog controls
   output logic             sys_clk_o,
   output logic             sys_tick_o,
   output logic             pll_enable_o,
   output logic      [1:0]  vco_band_o
);

   localparam int NSRC  = 4;                        // number of source pins
   localparam int ACC_W = N_W + P_W + 2;            // pll phase accumulator width
   localparam int DIV_W = (K1_W > K2_W) ? K1_W + 1 : K2_W + 1;

   // source index in the synchroniser bank
   localparam int S_EXT  = 0;
   localparam int S_XTAL = 1;
   localparam int S_INT  = 2;
   localparam int S_WAKE = 3;
   localparam int SEL_LSB = scs_pkg::SEL_LSB;       // select field position in its image

   // registers
   logic [1:0]      clock_source_select_reg;        // active select code
   logic            vco_bypass_reg;
   logic [1:0]      vco_band_select_reg;
   logic            pll_ref_reg;                    // 1 = internal source
   logic [P_W-1:0]  pll_input_divider_reg;
   logic [N_W-1:0]  pll_multiplier_reg;
   logic [K2_W-1:0] pll_output_divider_reg;
   logic [K1_W-1:0] prescaler_divider_reg;
   logic            presc_src_reg;                  // 1 = internal source

   // synchronisers and edge detection
   logic [NSRC-1:0] sync1_reg;                      // first stage, read only by sync2
   logic [NSRC-1:0] sync2_reg;                      // settled level
   logic [NSRC-1:0] sync3_reg;                      // previous settled level
   logic [NSRC-1:0] rise;                           // one-cycle rising edge

   // generation datapath
   logic [ACC_W-1:0] acc_reg;                       // pll phase accumulator
   logic [ACC_W-1:0] acc_next;
   logic             vco_tick;                      // one vco period elapsed
   logic [DIV_W-1:0] div_cnt_reg;                   // output divider count
   logic [DIV_W-1:0] div_cnt_next;
   logic [DIV_W-1:0] div_k;                         // active divide factor
   scs_pkg::scs_mode_e mode;                        // effective mode
   scs_pkg::scs_mode_e mode_prev_reg;               // mode last cycle
   logic             src_tick;                      // tick fed to divider
   logic             src_level;                     // level for pass-through
   logic             pass;                          // divide by one, pass level
   logic             sys_clk_next;
   logic             sys_tick_next;

   // bus
   logic             wb_req;
   logic             wb_wr;
   logic [31:0]      rd_data;

   // byte-lane merge of a write into an old register image
   function automatic logic [31:0] merge(input logic [31:0] old_v,
                                         input logic [31:0] new_v,
                                         input logic [3:0]  sel);
      logic [31:0] r;
      r = old_v;
      for (int b = 0; b < 4; b++)
      begin
         if (sel[b])
         begin
            r[8*b +: 8] = new_v[8*b +: 8];
         end
      end
      return r;
   endfunction

   // register images as seen on the bus
   logic [31:0] sys_img;
   logic [31:0] pll_img;
   logic [31:0] presc_img;
   logic [31:0] stat_img;
   logic [31:0] sys_w;
   logic [31:0] pll_w;
   logic [31:0] presc_w;

   always_comb
   begin
      sys_img = 32'h0;
      sys_img[SEL_LSB +: 2] = clock_source_select_reg;
      pll_img = 32'h0;
      pll_img[scs_pkg::BYP_BIT]           = vco_bypass_reg;
      pll_img[scs_pkg::BAND_LSB +: 2]     = vco_band_select_reg;
      pll_img[scs_pkg::PREF_BIT]          = pll_ref_reg;
      pll_img[scs_pkg::PLL_INPUT_DIVIDER_LSB +: P_W]   = pll_input_divider_reg;
      pll_img[scs_pkg::PLL_MULTIPLIER_LSB +: N_W]   = pll_multiplier_reg;
      pll_img[scs_pkg::K2_LSB +: K2_W]    = pll_output_divider_reg;
      presc_img = 32'h0;
      presc_img[scs_pkg::K1_LSB +: K1_W]  = prescaler_divider_reg;
      presc_img[scs_pkg::PSRC_BIT]        = presc_src_reg;
      stat_img = 32'h0;
      stat_img[scs_pkg::ST_SEL_LSB +: 2]  = clock_source_select_reg;
      stat_img[scs_pkg::ST_PLL_BIT]       = (mode == scs_pkg::MODE_PLL);
      stat_img[scs_pkg::ST_PRESC_BIT]     = (mode == scs_pkg::MODE_PRESC);
      sys_w   = merge(sys_img, wb_dat_i, wb_sel_i);
      pll_w   = merge(pll_img, wb_dat_i, wb_sel_i);
      presc_w = merge(presc_img, wb_dat_i, wb_sel_i);
   end

   // a request is answered once; ack drops the cycle after it was given
   assign wb_req = wb_cyc_i && wb_stb_i && !wb_ack_o;
   assign wb_wr  = wb_req && wb_we_i;

   // bus acknowledge, one cycle after the request is seen
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         wb_ack_o <= 1'b0;
      end
      else
      begin
         wb_ack_o <= wb_req;
      end
   end

   // read mux; unmapped offsets read zero and are still acknowledged
   always_comb
   begin
      unique case (wb_adr_i)
         scs_pkg::SYS_CTRL_OFS:   rd_data = sys_img;
         scs_pkg::PLL_CTRL_OFS:   rd_data = pll_img;
         scs_pkg::PRESC_CTRL_OFS: rd_data = presc_img;
         scs_pkg::STATUS_OFS:     rd_data = stat_img;
         default:                 rd_data = 32'h0;
      endcase
   end

   // read data register, loaded with the answer
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         wb_dat_o <= 32'h0;
      end
      else if (wb_req && !wb_we_i)
      begin
         wb_dat_o <= rd_data;
      end
   end

   // system control register; the reserved code is dropped on write
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         clock_source_select_reg <= scs_pkg::SEL_RST;
      end
      else if (wb_wr && wb_adr_i == scs_pkg::SYS_CTRL_OFS &&
               sys_w[SEL_LSB +: 2] != scs_pkg::SEL_RESERVED)
      begin
         clock_source_select_reg <= sys_w[SEL_LSB +: 2];
      end
   end

   // pll control register
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         vco_bypass_reg         <= scs_pkg::BYP_RST;
         vco_band_select_reg    <= scs_pkg::BAND_RST;
         pll_ref_reg            <= 1'b0;
         pll_input_divider_reg  <= '0;
         pll_multiplier_reg     <= '0;
         pll_output_divider_reg <= '0;
      end
      else if (wb_wr && wb_adr_i == scs_pkg::PLL_CTRL_OFS)
      begin
         vco_bypass_reg         <= pll_w[scs_pkg::BYP_BIT];
         vco_band_select_reg    <= pll_w[scs_pkg::BAND_LSB +: 2];
         pll_ref_reg            <= pll_w[scs_pkg::PREF_BIT];
         pll_input_divider_reg  <= pll_w[scs_pkg::PLL_INPUT_DIVIDER_LSB +: P_W];
         pll_multiplier_reg     <= pll_w[scs_pkg::PLL_MULTIPLIER_LSB +: N_W];
         pll_output_divider_reg <= pll_w[scs_pkg::K2_LSB +: K2_W];
      end
   end

   // prescaler control register; full 0..1023 range is writable
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         prescaler_divider_reg <= '0;
         presc_src_reg         <= 1'b0;
      end
      else if (wb_wr && wb_adr_i == scs_pkg::PRESC_CTRL_OFS)
      begin
         prescaler_divider_reg <= presc_w[scs_pkg::K1_LSB +: K1_W];
         presc_src_reg         <= presc_w[scs_pkg::PSRC_BIT];
      end
   end

   // two-flop synchronisers, plus a third flop for edge detection
   genvar gi;
   generate
      for (gi = 0; gi < NSRC; gi++)
      begin : g_sync
         logic pin;
         if (gi == S_EXT)       assign pin = ext_clock_pin_i;
         else if (gi == S_XTAL) assign pin = crystal_input_pin_i;
         else if (gi == S_INT)  assign pin = int_clock_i;
         else                   assign pin = wakeup_clock_i;

         always_ff @(posedge clk_i)
         begin
            if (rst_i)
            begin
               sync1_reg[gi] <= 1'b0;
               sync2_reg[gi] <= 1'b0;
               sync3_reg[gi] <= 1'b0;
            end
            else
            begin
               sync1_reg[gi] <= pin;
               sync2_reg[gi] <= sync1_reg[gi];
               sync3_reg[gi] <= sync2_reg[gi];
            end
         end

         assign rise[gi] = sync2_reg[gi] && !sync3_reg[gi];
      end
   endgenerate

   // mode decode from select code and bypass bit
   always_comb
   begin
      unique case (clock_source_select_reg)
         scs_pkg::SEL_DIRECT:    mode = scs_pkg::MODE_DIRECT;
         scs_pkg::SEL_GENERATOR: mode = vco_bypass_reg ?
                                        scs_pkg::MODE_PRESC :
                                        scs_pkg::MODE_PLL;
         default:                mode = scs_pkg::MODE_WAKE;
      endcase
   end

   // pll model: each reference edge adds N, each vco period costs P,
   // so vco rate is f_ref * N / P; at most one vco tick per clk_i cycle
   assign vco_tick = (mode == scs_pkg::MODE_PLL) &&
                     (acc_reg >= ACC_W'(pll_input_divider_reg) + ACC_W'(1));

   always_comb
   begin
      acc_next = acc_reg;
      if (rise[pll_ref_reg ? S_INT : S_XTAL])
      begin
         acc_next = acc_next + ACC_W'(pll_multiplier_reg) + ACC_W'(1);
      end
      if (vco_tick)
      begin
         acc_next = acc_next - ACC_W'(pll_input_divider_reg) - ACC_W'(1);
      end
   end

   // accumulator is cleared whenever the pll is disabled
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         acc_reg <= '0;
      end
      else if (mode != scs_pkg::MODE_PLL)
      begin
         acc_reg <= '0;
      end
      else
      begin
         acc_reg <= acc_next;
      end
   end

   // source tick, level and divide factor for the active mode
   always_comb
   begin
      src_tick  = 1'b0;
      src_level = 1'b0;
      div_k     = DIV_W'(1);
      unique case (mode)
         scs_pkg::MODE_DIRECT:
         begin
            src_tick  = rise[S_EXT];
            src_level = sync2_reg[S_EXT];
         end
         scs_pkg::MODE_PRESC:
         begin
            src_tick  = rise[presc_src_reg ? S_INT : S_XTAL];
            src_level = sync2_reg[presc_src_reg ? S_INT : S_XTAL];
            div_k     = DIV_W'(prescaler_divider_reg) + DIV_W'(1);
         end
         scs_pkg::MODE_PLL:
         begin
            src_tick  = vco_tick;
            src_level = vco_tick;
            div_k     = DIV_W'(pll_output_divider_reg) + DIV_W'(1);
         end
         default:
         begin
            src_tick  = rise[S_WAKE];
            src_level = sync2_reg[S_WAKE];
         end
      endcase
   end

   // divide by one passes the source level straight through
   assign pass = (div_k == DIV_W'(1));

   // output divider: one system period per div_k source ticks; the
   // high phase spans the first half, rounded up
   always_comb
   begin
      div_cnt_next  = div_cnt_reg;
      sys_tick_next = 1'b0;
      if (src_tick)
      begin
         if (div_cnt_reg >= div_k - DIV_W'(1))
         begin
            div_cnt_next  = '0;
            sys_tick_next = 1'b1;
         end
         else
         begin
            div_cnt_next = div_cnt_reg + DIV_W'(1);
         end
      end
      if (pass)
      begin
         sys_clk_next = src_level;
      end
      else
      begin
         sys_clk_next = (div_cnt_next < ((div_k + DIV_W'(1)) >> 1));
      end
   end

   // divider state restarts on any mode change so no stale count leaks
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         div_cnt_reg   <= '0;
         mode_prev_reg <= scs_pkg::MODE_WAKE;
      end
      else
      begin
         mode_prev_reg <= mode;
         div_cnt_reg   <= (mode != mode_prev_reg) ? '0 : div_cnt_next;
      end
   end

   // registered outputs
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         sys_clk_o    <= 1'b0;
         sys_tick_o   <= 1'b0;
         pll_enable_o <= 1'b0;
         vco_band_o   <= scs_pkg::BAND_RST;
      end
      else
      begin
         sys_clk_o    <= sys_clk_next;
         sys_tick_o   <= sys_tick_next;
         pll_enable_o <= (mode == scs_pkg::MODE_PLL);
         vco_band_o   <= vco_band_select_reg;
      end
   end

endmodule

// ===== core/scs_pkg.sv
/*
 * scs_pkg: shared constants for the system clock source select block:
 * register offsets, field positions, reset values and select codes.
 * assumes a 32-bit classic wishbone bus with word-aligned byte addresses.
 */
package scs_pkg;

   // register byte offsets
   localparam logic [3:0] SYS_CTRL_OFS    = 4'h0;   // system_control_reg
   localparam logic [3:0] PLL_CTRL_OFS    = 4'h4;   // pll_control_reg
   localparam logic [3:0] PRESC_CTRL_OFS  = 4'h8;   // prescaler_control_reg
   localparam logic [3:0] STATUS_OFS      = 4'hC;   // clock_status_reg

   // system_control_reg fields
   localparam int SEL_LSB        = 0;               // clock_source_select [1:0]

   // pll_control_reg fields
   localparam int BYP_BIT        = 0;               // vco_bypass
   localparam int BAND_LSB       = 1;               // vco_band_select [2:1]
   localparam int PREF_BIT       = 3;               // pll reference: 0 crystal, 1 internal
   localparam int PLL_INPUT_DIVIDER_LSB       = 4;               // pll_input_divider
   localparam int PLL_MULTIPLIER_LSB       = 8;               // pll_multiplier
   localparam int K2_LSB         = 16;              // pll_output_divider

   // prescaler_control_reg fields
   localparam int K1_LSB         = 0;               // prescaler_divider [9:0]
   localparam int PSRC_BIT       = 16;              // prescaler source: 0 crystal, 1 internal

   // clock_status_reg fields
   localparam int ST_SEL_LSB     = 0;               // active select [1:0]
   localparam int ST_PLL_BIT     = 2;               // pll running
   localparam int ST_PRESC_BIT   = 3;               // prescaler running

   // clock source select codes
   localparam logic [1:0] SEL_WAKEUP    = 2'h0;
   localparam logic [1:0] SEL_RESERVED  = 2'h1;
   localparam logic [1:0] SEL_GENERATOR = 2'h2;
   localparam logic [1:0] SEL_DIRECT    = 2'h3;

   // vco band codes
   localparam logic [1:0] BAND_LOW  = 2'h0;         // 50 to 110 MHz controlled
   localparam logic [1:0] BAND_HIGH = 2'h1;         // 100 to 160 MHz controlled

   // reset values: wakeup clock, vco bypassed, all dividers at one
   localparam logic [1:0] SEL_RST   = SEL_WAKEUP;
   localparam logic       BYP_RST   = 1'b1;
   localparam logic [1:0] BAND_RST  = BAND_LOW;

   // effective generation mode, one-hot
   typedef enum logic [3:0]
   {
      MODE_WAKE   = 4'b0001,
      MODE_DIRECT = 4'b0010,
      MODE_PRESC  = 4'b0100,
      MODE_PLL    = 4'b1000
   } scs_mode_e;

endpackage

// ===== tb/scs_clock_select_props.sv
/*
 * scs_clock_select_props: port-level assertions for the clock source block.
 * assumes it is bound to scs_clock_select and sees only that module's ports.
 */
`timescale 1ns/1ns
module scs_clock_select_props
(
   // clock and reset
   input wire logic        clk_i,
   input wire logic        rst_i,
   // wishbone slave
   input wire logic        wb_cyc_i,
   input wire logic        wb_stb_i,
   input wire logic        wb_we_i,
   input wire logic [3:0]  wb_adr_i,
   input wire logic [3:0]  wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   input wire logic [31:0] wb_dat_o,
   input wire logic        wb_ack_o,
   // source pins
   input wire logic        ext_clock_pin_i,
   input wire logic        crystal_input_pin_i,
   input wire logic        int_clock_i,
   input wire logic        wakeup_clock_i,
   // generated outputs
   input wire logic        sys_clk_o,
   input wire logic        sys_tick_o,
   input wire logic        pll_enable_o,
   input wire logic [1:0]  vco_band_o
);
   logic [1:0] sel_m;                               // mirrored clock_source_select
   logic       byp_m;                               // mirrored vco_bypass
   logic [1:0] band_m;                              // mirrored vco_band_select
   logic [3:0] quiet;                               // cycles since last select write
   logic       wr_take;                             // write accepted at this edge
   logic       want_pll;                            // mirror says pll mode

   assign wr_take  = wb_cyc_i && wb_stb_i && wb_we_i && !wb_ack_o;
   assign want_pll = (sel_m == scs_pkg::SEL_GENERATOR) && !byp_m;

   // mirror the control fields at the same edge the block takes a write
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         sel_m  <= scs_pkg::SEL_RST;
         byp_m  <= scs_pkg::BYP_RST;
         band_m <= scs_pkg::BAND_RST;
      end
      else if (wr_take && wb_sel_i[0])
      begin
         // the reserved code is dropped, as the block must drop it
         if (wb_adr_i == scs_pkg::SYS_CTRL_OFS && wb_dat_i[1:0] != scs_pkg::SEL_RESERVED)
            sel_m <= wb_dat_i[1:0];
         if (wb_adr_i == scs_pkg::PLL_CTRL_OFS)
         begin
            byp_m  <= wb_dat_i[scs_pkg::BYP_BIT];
            band_m <= wb_dat_i[scs_pkg::BAND_LSB +: 2];
         end
      end
   end

   // settle counter; saturates so it never wraps back into a check window
   always_ff @(posedge clk_i)
   begin
      if (rst_i || (wr_take && wb_adr_i == scs_pkg::SYS_CTRL_OFS))
         quiet <= 4'h0;
      else if (quiet != 4'hF)
         quiet <= quiet + 4'h1;
   end

   default clocking @(posedge clk_i); endclocking
   default disable iff (rst_i);

   // a request the slave has not yet answered
   sequence req_s;
      wb_cyc_i && wb_stb_i && !wb_ack_o;
   endsequence

   ack_follow_a: assert property (req_s |=> wb_ack_o)
      else $error("ack missing one cycle after request");
   ack_single_a: assert property (wb_ack_o |=> !wb_ack_o)
      else $error("ack longer than one cycle");
   ack_idle_a: assert property (!(wb_cyc_i && wb_stb_i) |=> !wb_ack_o)
      else $error("ack without request");
   pll_on_a: assert property (want_pll && $past(want_pll) |-> pll_enable_o)
      else $error("pll not enabled in pll mode");
   pll_off_a: assert property (!want_pll && !$past(want_pll) |-> !pll_enable_o)
      else $error("pll enabled outside pll mode");
   band_follow_a: assert property ($stable(band_m) |-> vco_band_o == band_m)
      else $error("band output differs from band field");
   // middle of a pin phase only, so one cycle of sync latency either way passes
   direct_pin_a: assert property ((sel_m == scs_pkg::SEL_DIRECT) && quiet > 4'h9
      && $past(ext_clock_pin_i, 3) == $past(ext_clock_pin_i, 5)
      |-> sys_clk_o == $past(ext_clock_pin_i, 4))
      else $error("system clock does not follow external pin");
   wake_pin_a: assert property ((sel_m == scs_pkg::SEL_WAKEUP) && quiet > 4'h9
      && $past(wakeup_clock_i, 3) == $past(wakeup_clock_i, 5)
      |-> sys_clk_o == $past(wakeup_clock_i, 4))
      else $error("system clock does not follow wakeup clock");
endmodule

bind scs_clock_select scs_clock_select_props i_scs_clock_select_props
(
   .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
   .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
   .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .ext_clock_pin_i(ext_clock_pin_i),
   .crystal_input_pin_i(crystal_input_pin_i), .int_clock_i(int_clock_i),
   .wakeup_clock_i(wakeup_clock_i), .sys_clk_o(sys_clk_o), .sys_tick_o(sys_tick_o),
   .pll_enable_o(pll_enable_o), .vco_band_o(vco_band_o)
);

// ===== tb/tb.sv
/*
 * tb: register and clock-period tests for scs_clock_select.
 * assumes the 1-cycle wishbone answer of the block and source clocks that
 * the bench makes itself: ext 8, crystal 10, internal 12, wakeup 32 cycles.
 */
`timescale 1ns/1ns
module tb;
   // design inputs, all given a value at time zero
   logic        clk_i = 1'b0;
   logic        rst_i = 1'b1;
   logic        wb_cyc_i = 1'b0;
   logic        wb_stb_i = 1'b0;
   logic        wb_we_i = 1'b0;
   logic [3:0]  wb_adr_i = 4'h0;
   logic [3:0]  wb_sel_i = 4'hF;
   logic [31:0] wb_dat_i = 32'h0;
   logic        ext_clock_pin_i = 1'b0;
   logic        crystal_input_pin_i = 1'b0;
   logic        int_clock_i = 1'b0;
   logic        wakeup_clock_i = 1'b0;
   // design outputs
   logic [31:0] wb_dat_o;
   logic        wb_ack_o;
   logic        sys_clk_o;
   logic        sys_tick_o;
   logic        pll_enable_o;
   logic [1:0]  vco_band_o;
   // bench state
   logic [15:0] src_cnt = 16'h0;                    // timebase for ext and wakeup
   logic [3:0]  xt_cnt = 4'h0;                      // crystal phase, mod 10
   logic [3:0]  ic_cnt = 4'h0;                      // internal phase, mod 12
   logic [31:0] rd_q;                               // data taken at ack
   int          num_errors = 0;
   int          compares = 0;
   // prescaler cases: config word, ticks spanned, expected cycles
   logic [31:0] ps_cfg [4] = '{32'h0, 32'h2, 32'h10001, 32'h3FF};
   int          ps_n [4] = '{2, 2, 2, 1};
   logic [31:0] ps_exp [4] = '{32'h14, 32'h3C, 32'h30, 32'h2800};
   // pll cases: crystal P1 N4 K2=2 band low; internal P2 N4 K2=1 band high
   logic [31:0] pl_cfg [2] = '{32'h00010300, 32'h0000031A};
   logic [31:0] pl_exp [2] = '{32'h14, 32'h18};

   always #10 clk_i = ~clk_i;

   // source clocks; each phase spans at least two cycles for the synchronisers
   always @(posedge clk_i)
   begin
      src_cnt <= src_cnt + 16'h1;
      xt_cnt <= (xt_cnt == 4'h9) ? 4'h0 : xt_cnt + 4'h1;
      ic_cnt <= (ic_cnt == 4'hB) ? 4'h0 : ic_cnt + 4'h1;
      ext_clock_pin_i <= src_cnt[2];
      wakeup_clock_i <= src_cnt[4];
      crystal_input_pin_i <= (xt_cnt < 4'h5);
      int_clock_i <= (ic_cnt < 4'h6);
   end

   scs_clock_select i_scs_clock_select
   (
      .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
      .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
      .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .ext_clock_pin_i(ext_clock_pin_i),
      .crystal_input_pin_i(crystal_input_pin_i), .int_clock_i(int_clock_i),
      .wakeup_clock_i(wakeup_clock_i), .sys_clk_o(sys_clk_o), .sys_tick_o(sys_tick_o),
      .pll_enable_o(pll_enable_o), .vco_band_o(vco_band_o)
   );

   // value compare, four-state exact
   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      compares++;
      if (got !== exp)
      begin
         $display("unexpected %s: expected %h seen %h", what, exp, got);
         num_errors++;
      end
   endtask

   // one classic cycle; held until ack is sampled, then released
   task automatic bus(input logic w, input logic [3:0] adr, input logic [31:0] dat);
      int n;
      n = 0;
      @(posedge clk_i);
      wb_cyc_i <= 1'b1;
      wb_stb_i <= 1'b1;
      wb_we_i <= w;
      wb_adr_i <= adr;
      wb_sel_i <= 4'hF;
      wb_dat_i <= dat;
      @(posedge clk_i);
      while (wb_ack_o !== 1'b1 && n < 20)
      begin
         @(posedge clk_i);
         n++;
      end
      rd_q = wb_dat_o;
      if (n == 20)
         chk("bus ack", 32'h1, 32'h0);
      wb_cyc_i <= 1'b0;
      wb_stb_i <= 1'b0;
      wb_we_i <= 1'b0;
   endtask

   task automatic rd(input logic [3:0] adr, input logic [31:0] exp);
      bus(1'b0, adr, 32'h0);
      chk($sformatf("register %h", adr), exp, rd_q);
   endtask

   // cycles across n ticks; one period is skipped so a divider change cannot skew it
   task automatic span(input int n, input logic [31:0] exp);
      int c;
      int k;
      c = 0;
      k = 0;
      while (k < n + 2 && c < 40000)
      begin
         @(posedge clk_i);
         c++;
         if (sys_tick_o === 1'b1)
         begin
            k++;
            if (k == 2)
               c = 0;
         end
      end
      chk("tick span", exp, c);
   endtask

   task automatic stop_test;
      if (num_errors == 0 && compares > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask

   // watchdog: the whole run needs some 31000 cycles
   initial
   begin
      repeat (80000) @(posedge clk_i);
      num_errors++;
      stop_test();
   end

   initial
   begin
      repeat (4) @(posedge clk_i);
      rst_i <= 1'b0;
      rd(4'h0, 32'h0);
      rd(4'h4, 32'h1);
      rd(4'h8, 32'h0);
      rd(4'hC, 32'h0);
      rd(4'h6, 32'h0);
      span(2, 32'h40);
      bus(1'b1, 4'h0, 32'h3);
      rd(4'hC, 32'h3);
      span(4, 32'h20);
      bus(1'b1, 4'h0, 32'h1);
      rd(4'h0, 32'h3);
      span(2, 32'h10);
      bus(1'b1, 4'hC, 32'hFFFFFFFF);
      rd(4'hC, 32'h3);
      // divider first, then the select, so no stray setting is passed through
      for (int i = 0; i < 4; i++)
      begin
         bus(1'b1, 4'h8, ps_cfg[i]);
         bus(1'b1, 4'h0, 32'h2);
         rd(4'hC, 32'hA);
         span(ps_n[i], ps_exp[i]);
      end
      for (int i = 0; i < 2; i++)
      begin
         bus(1'b1, 4'h4, pl_cfg[i]);
         rd(4'hC, 32'h6);
         chk("pll enable", 32'h1, {31'h0, pll_enable_o});
         chk("vco band", i, {30'h0, vco_band_o});
         repeat (60) @(posedge clk_i);
         span(4, pl_exp[i]);
      end
      bus(1'b1, 4'h0, 32'h0);
      rd(4'hC, 32'h0);
      chk("pll enable", 32'h0, {31'h0, pll_enable_o});
      stop_test();
   end
endmodule
